// ==== include/ddr_pkg.sv ====
// shared constants and types for the diagnostic results and readback block
`default_nettype none
package ddr_pkg;
    // serial frame geometry
    localparam int FRAME_LONG  = 32;
    localparam int FRAME_SHORT = 24;
    localparam int EDGE_W      = 6;
    localparam int CRC_BITS    = 8;

    // register addresses used by this block
    localparam logic [4:0] ADDR_NOP          = 5'h00;
    localparam logic [4:0] ADDR_DAC_OUTPUT   = 5'h02;
    localparam logic [4:0] ADDR_DAC_CONFIG   = 5'h06;
    localparam logic [4:0] ADDR_GP_CONFIG2   = 5'h0a;
    localparam logic [4:0] ADDR_WDT_CONFIG   = 5'h0f;
    localparam logic [4:0] ADDR_READBACK_SEL = 5'h13;
    localparam logic [4:0] ADDR_DIAG_RESULTS = 5'h14;
    localparam logic [4:0] ADDR_STATUS       = 5'h16;
    localparam logic [4:0] ADDR_FREQ_MONITOR = 5'h18;
    localparam logic [4:0] ADDR_DEVICE_ID_3  = 5'h1c;

    // incoming command word fields (24 bit part of a frame)
    localparam int CMD_ADDR_LSB = 16;
    localparam int CMD_DATA_W   = 16;

    // diagnostic results register layout and reset value
    localparam logic [23:0] DIAG_RESET    = 24'h14a000;
    localparam int          BIT_FAULT_PIN = 21;
    localparam int          BIT_CAL_UNREF = 15;
    localparam int          BIT_SLEW_BUSY = 14;
    localparam int          BIT_RESET_OCC = 13;
    localparam int          BIT_WDT_ERR   = 11;
    localparam int          BIT_LATCH_ERR = 8;
    localparam int          BIT_INV_ERR   = 6;
    localparam int          BIT_CRC_ERR   = 5;
    localparam int          BIT_INVALID   = 4;
    localparam int          BIT_SCLK_ERR  = 2;
    localparam logic [23:0] STICKY_MASK   = 24'h002974;
    localparam logic [23:0] ENABLE_MASK   = 24'h000974;

    // readback select register layout and reset values
    localparam int         SEL_LSB    = 0;
    localparam int         MODE_LSB   = 5;
    localparam logic [4:0] SEL_RESET  = 5'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // output range field of the dac configuration register
    localparam int         RANGE_LSB   = 0;
    localparam int         RANGE_W     = 4;
    localparam logic [3:0] RANGE_RESET = 4'h0;

    // frame as captured on the link side
    typedef struct packed {
        logic [31:0]       bits;
        logic [EDGE_W-1:0] edges;
        logic              tog;
    } ddr_rx_t;

    // decoded command handed to the register side
    typedef struct packed {
        logic [4:0]            addr;
        logic [CMD_DATA_W-1:0] data;
    } ddr_cmd_t;

    // present state of the digital diagnostic sources
    typedef struct packed {
        logic wdt;
        logic latch;
        logic inverse;
        logic cal_crc;
    } ddr_diag_cond_t;

    // calibration memory refresh sequencing
    typedef enum logic [1:0] {
        REF_IDLE,
        REF_REQ,
        REF_WAIT
    } ddr_ref_state_t;
endpackage
`default_nettype wire

// ==== logic/ddr_spi_link.sv ====
// serial link end: frame shifter and readback bit select on the link clock
`timescale 1ns/1ps
`default_nettype none
module ddr_spi_link (
    // link clock, frame select, reset
    input  wire logic             sclk,
    input  wire logic             sync_n,
    input  wire logic             nrst,
    // serial data
    input  wire logic             sdi,
    output logic                  sdo,
    // words crossing to and from the register side
    input  wire logic [31:0]      tx_word,
    output ddr_pkg::ddr_rx_t      rx
);
    logic                         first;
    logic [31:0]                  shift;
    logic [ddr_pkg::EDGE_W-1:0]   edges;
    logic                         tog;
    logic [31:0]                  next_shift;
    logic [ddr_pkg::EDGE_W-1:0]   next_edges;
    logic                         next_tog;
    logic                         next_sdo;
    logic [ddr_pkg::EDGE_W-1:0]   bit_idx;

    // next values: count falling edges, shift in, toggle once per frame
    always_comb begin
        next_shift = {shift[30:0], sdi};
        next_tog   = first ? ~tog : tog;
        next_edges = edges;
        if (first) begin
            next_edges = ddr_pkg::EDGE_W'(1);
        end else if (edges != {ddr_pkg::EDGE_W{1'b1}}) begin
            next_edges = edges + ddr_pkg::EDGE_W'(1);
        end
        bit_idx  = first ? '0 : edges;
        next_sdo = 1'b0;
        if (bit_idx < ddr_pkg::EDGE_W'(ddr_pkg::FRAME_LONG)) begin
            next_sdo = tx_word[5'(31 - int'(bit_idx))];
        end
    end

    // first edge flag, cleared by the first falling edge of a frame
    always_ff @(negedge sclk or posedge sync_n) begin
        if (sync_n) begin
            first <= 1'b1;
        end else begin
            first <= 1'b0;
        end
    end

    // capture registers hold their value after the frame for the crossing
    always_ff @(negedge sclk or negedge nrst) begin
        if (!nrst) begin
            shift <= '0;
            edges <= '0;
            tog   <= 1'b0;
        end else begin
            shift <= next_shift;
            edges <= next_edges;
            tog   <= next_tog;
        end
    end

    // readback bit launched on the rising edge, quiet between frames
    always_ff @(posedge sclk or posedge sync_n) begin
        if (sync_n) begin
            sdo <= 1'b0;
        end else begin
            sdo <= next_sdo;
        end
    end

    assign rx = '{bits: shift, edges: edges, tog: tog};
endmodule
`default_nettype wire

// ==== logic/ddr_diag_results.sv ====
// diagnostic results register and two-stage readback select behind the serial port
`timescale 1ns/1ps
`default_nettype none
module ddr_diag_results (
    // system clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       nrst,
    // serial port pins
    input  wire logic                       sclk,
    input  wire logic                       sync_n,
    input  wire logic                       sdi,
    output logic                            sdo,
    // device status inputs
    input  wire logic                       fault_pin,
    input  wire logic                       slew_active,
    input  wire logic                       crc_enable,
    input  wire logic [23:0]                diag_enable,
    input  wire ddr_pkg::ddr_diag_cond_t    diag_cond,
    // calibration memory refresh
    output logic                            cal_start,
    input  wire logic                       cal_done,
    output logic [ddr_pkg::RANGE_W-1:0]     dac_range,
    // other registers of the device
    output logic                            wr_valid,
    output ddr_pkg::ddr_cmd_t               wr_cmd,
    output logic [4:0]                      rd_select,
    input  wire logic [15:0]                rd_data
);
    // sync and fault pin synchronisers
    logic                           sync_q1;
    logic                           sync_q2;
    logic                           sync_q3;
    logic                           fault_q1;
    logic                           fault_q2;
    // register state
    logic [23:0]                    flags;
    logic                           cal_unref;
    logic [1:0]                     mode;
    logic                           last_tog;
    logic [31:0]                    tx_word;
    ddr_pkg::ddr_ref_state_t        ref_state;
    // next values
    logic [23:0]                    next_flags;
    logic                           next_cal_unref;
    logic [4:0]                     next_select;
    logic [1:0]                     next_mode;
    logic [ddr_pkg::RANGE_W-1:0]    next_range;
    logic                           next_last_tog;
    logic [31:0]                    next_tx_word;
    logic                           next_wr_valid;
    ddr_pkg::ddr_cmd_t              next_wr_cmd;
    logic                           next_cal_start;
    ddr_pkg::ddr_ref_state_t        next_ref_state;
    // frame decode
    ddr_pkg::ddr_rx_t               rx;
    ddr_pkg::ddr_cmd_t              cmd;
    logic                           frame_end;
    logic                           len_ok;
    logic                           bad_access;
    logic                           do_write;
    logic                           range_change;
    logic [23:0]                    event_vec;
    logic [23:0]                    w1_vec;
    logic [23:0]                    diag_view;
    logic [23:0]                    rd_value;

    // address in the register map at all
    function automatic logic addr_valid(input logic [4:0] a);
        addr_valid = (a <= ddr_pkg::ADDR_GP_CONFIG2) ||
                     ((a >= ddr_pkg::ADDR_WDT_CONFIG) && (a <= ddr_pkg::ADDR_FREQ_MONITOR)) ||
                     (a == ddr_pkg::ADDR_DEVICE_ID_3);
    endfunction

    // registers that accept no write
    function automatic logic addr_read_only(input logic [4:0] a);
        addr_read_only = (a == ddr_pkg::ADDR_DAC_OUTPUT) ||
                         ((a >= ddr_pkg::ADDR_STATUS) && (a <= ddr_pkg::ADDR_FREQ_MONITOR)) ||
                         (a == ddr_pkg::ADDR_DEVICE_ID_3);
    endfunction

    ddr_spi_link u_link (
        .sclk    (sclk),
        .sync_n  (sync_n),
        .nrst    (nrst),
        .sdi     (sdi),
        .sdo     (sdo),
        .tx_word (tx_word),
        .rx      (rx)
    );

    // frame end detection and command decode; rx is static once sync_n is high
    always_comb begin
        frame_end = sync_q2 & ~sync_q3;
        len_ok    = (rx.tog != last_tog) &&
                    ((rx.edges == ddr_pkg::EDGE_W'(ddr_pkg::FRAME_LONG)) ||
                     (!crc_enable && rx.edges == ddr_pkg::EDGE_W'(ddr_pkg::FRAME_SHORT)));
        if (rx.edges == ddr_pkg::EDGE_W'(ddr_pkg::FRAME_LONG)) begin
            cmd = ddr_pkg::ddr_cmd_t'(rx.bits[ddr_pkg::CRC_BITS +: 21]);
        end else begin
            cmd = ddr_pkg::ddr_cmd_t'(rx.bits[20:0]);
        end
        bad_access = !addr_valid(cmd.addr) ||
                     addr_read_only(cmd.addr) ||
                     (cal_unref && cmd.addr != ddr_pkg::ADDR_READBACK_SEL &&
                      cmd.addr != ddr_pkg::ADDR_NOP);
        if (cmd.addr == ddr_pkg::ADDR_READBACK_SEL && !addr_valid(cmd.data[4:0])) begin
            bad_access = 1'b1;
        end
        do_write     = frame_end && len_ok && !bad_access;
        range_change = do_write && cmd.addr == ddr_pkg::ADDR_DAC_CONFIG &&
                       cmd.data[ddr_pkg::RANGE_LSB +: ddr_pkg::RANGE_W] != dac_range;
    end

    // sticky flags: events set, a written 1 reloads the present condition
    always_comb begin
        event_vec                         = '0;
        event_vec[ddr_pkg::BIT_WDT_ERR]   = diag_cond.wdt;
        event_vec[ddr_pkg::BIT_LATCH_ERR] = diag_cond.latch;
        event_vec[ddr_pkg::BIT_INV_ERR]   = diag_cond.inverse;
        event_vec[ddr_pkg::BIT_CRC_ERR]   = diag_cond.cal_crc;
        event_vec[ddr_pkg::BIT_INVALID]   = frame_end && len_ok && bad_access;
        event_vec[ddr_pkg::BIT_SCLK_ERR]  = frame_end && !len_ok;
        w1_vec = '0;
        if (do_write && cmd.addr == ddr_pkg::ADDR_DIAG_RESULTS) begin
            w1_vec = {8'h00, cmd.data} & ddr_pkg::STICKY_MASK;
        end
        next_flags = ((flags & ~w1_vec) | event_vec) & ddr_pkg::STICKY_MASK;
    end

    // readback view of the diagnostic results register
    always_comb begin
        diag_view = flags & (~ddr_pkg::ENABLE_MASK | diag_enable);
        diag_view[ddr_pkg::BIT_FAULT_PIN] = fault_q2;
        diag_view[20:16]                  = ddr_pkg::ADDR_DIAG_RESULTS;
        diag_view[ddr_pkg::BIT_CAL_UNREF] = cal_unref;
        diag_view[ddr_pkg::BIT_SLEW_BUSY] = slew_active;
    end

    // value of the register named by the select field
    always_comb begin
        case (rd_select)
            ddr_pkg::ADDR_DIAG_RESULTS: begin
                rd_value = diag_view;
            end
            ddr_pkg::ADDR_READBACK_SEL: begin
                rd_value = {2'b00, fault_q2, ddr_pkg::ADDR_READBACK_SEL, 9'h000, mode, rd_select};
            end
            ddr_pkg::ADDR_DAC_CONFIG: begin
                rd_value = {2'b00, fault_q2, rd_select, rd_data[15:ddr_pkg::RANGE_W], dac_range};
            end
            default: begin
                rd_value = {2'b00, fault_q2, rd_select, rd_data};
            end
        endcase
    end

    // select, mode, range, write strobe and readback word
    always_comb begin
        next_select   = rd_select;
        next_mode     = mode;
        next_range    = dac_range;
        next_last_tog = frame_end ? rx.tog : last_tog;
        next_wr_valid = do_write && cmd.addr != ddr_pkg::ADDR_NOP;
        next_wr_cmd   = next_wr_valid ? cmd : wr_cmd; // command word moves only with its strobe
        if (do_write && cmd.addr == ddr_pkg::ADDR_READBACK_SEL) begin
            next_select = cmd.data[ddr_pkg::SEL_LSB +: 5];
            next_mode   = cmd.data[ddr_pkg::MODE_LSB +: 2];
        end
        if (range_change) begin
            next_range = cmd.data[ddr_pkg::RANGE_LSB +: ddr_pkg::RANGE_W];
        end
        // frozen while a frame is in progress
        next_tx_word = tx_word;
        if (sync_q2) begin
            next_tx_word = {rd_value, {ddr_pkg::CRC_BITS{1'b0}}};
        end
    end

    // calibration memory refresh sequencing
    always_comb begin
        next_ref_state = ref_state;
        case (ref_state)
            ddr_pkg::REF_IDLE: begin
                if (range_change) begin
                    next_ref_state = ddr_pkg::REF_REQ;
                end
            end
            ddr_pkg::REF_REQ: begin
                next_ref_state = ddr_pkg::REF_WAIT;
            end
            ddr_pkg::REF_WAIT: begin
                if (range_change) begin
                    next_ref_state = ddr_pkg::REF_REQ;
                end else if (cal_done) begin
                    next_ref_state = ddr_pkg::REF_IDLE;
                end
            end
            default: begin
                next_ref_state = ddr_pkg::REF_REQ;
            end
        endcase
        next_cal_start = (ref_state == ddr_pkg::REF_REQ); // pulse also for the request held in reset
        next_cal_unref = (next_ref_state != ddr_pkg::REF_IDLE);
    end

    // synchronisers for the frame select and fault pins
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync_q1  <= 1'b1;
            sync_q2  <= 1'b1;
            sync_q3  <= 1'b1;
            fault_q1 <= 1'b0;
            fault_q2 <= 1'b0;
        end else begin
            sync_q1  <= sync_n;
            sync_q2  <= sync_q1;
            sync_q3  <= sync_q2;
            fault_q1 <= fault_pin;
            fault_q2 <= fault_q1;
        end
    end

    // register state
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flags     <= ddr_pkg::DIAG_RESET & ddr_pkg::STICKY_MASK;
            cal_unref <= ddr_pkg::DIAG_RESET[ddr_pkg::BIT_CAL_UNREF];
            rd_select <= ddr_pkg::SEL_RESET;
            mode      <= ddr_pkg::MODE_RESET;
            dac_range <= ddr_pkg::RANGE_RESET;
            last_tog  <= 1'b0;
            tx_word   <= '0;
            wr_valid  <= 1'b0;
            wr_cmd    <= '0;
            cal_start <= 1'b0;
            ref_state <= ddr_pkg::REF_REQ;
        end else begin
            flags     <= next_flags;
            cal_unref <= next_cal_unref;
            rd_select <= next_select;
            mode      <= next_mode;
            dac_range <= next_range;
            last_tog  <= next_last_tog;
            tx_word   <= next_tx_word;
            wr_valid  <= next_wr_valid;
            wr_cmd    <= next_wr_cmd;
            cal_start <= next_cal_start;
            ref_state <= next_ref_state;
        end
    end
endmodule
`default_nettype wire

// ==== tb/ddr_diag_results_sva.sv ====
// assertion checker for the diagnostic results block
`timescale 1ns/1ps
`default_nettype none
module ddr_diag_results_sva (
    // clock and reset
    input wire logic                        sys_clk,
    input wire logic                        nrst,
    // watched ports
    input wire logic                        sync_n,
    input wire logic                        sdo,
    input wire logic                        cal_start,
    input wire logic [ddr_pkg::RANGE_W-1:0] dac_range,
    input wire logic                        wr_valid,
    input wire ddr_pkg::ddr_cmd_t           wr_cmd,
    input wire logic [4:0]                  rd_select
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // serial output quiet between frames
    property p_sdo_idle;
        sync_n && $past(sync_n) |-> !sdo;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven outside a frame");
    // refresh start is a single pulse
    property p_cal_pulse;
        cal_start |=> !cal_start;
    endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("cal_start longer than one cycle");
    // write strobe is a single pulse
    property p_wr_pulse;
        wr_valid |=> !wr_valid;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("wr_valid longer than one cycle");
    // a range change starts a refresh
    property p_range_cal;
        $changed(dac_range) |-> ##[0:2] cal_start;
    endproperty
    a_range_cal: assert property (p_range_cal) else $error("range change without refresh");
    // range copy follows an accepted config write
    property p_range_src;
        wr_valid && wr_cmd.addr == ddr_pkg::ADDR_DAC_CONFIG |-> dac_range == wr_cmd.data[3:0];
    endproperty
    a_range_src: assert property (p_range_src) else $error("range copy does not match write");
    // select only moves on an accepted select write
    property p_sel_src;
        $changed(rd_select) |-> wr_valid && wr_cmd.addr == ddr_pkg::ADDR_READBACK_SEL;
    endproperty
    a_sel_src: assert property (p_sel_src) else $error("select changed without select write");
    // select never holds a reserved code
    property p_sel_legal;
        !(rd_select inside {[5'h0b:5'h0e], [5'h19:5'h1b], [5'h1d:5'h1f]});
    endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("reserved select code stored");
    // no write passes to nop, reserved or read-only places
    property p_wr_legal;
        wr_valid |-> !(wr_cmd.addr inside {5'h00, 5'h02, [5'h0b:5'h0e], [5'h16:5'h1f]});
    endproperty
    a_wr_legal: assert property (p_wr_legal) else $error("write passed to illegal address");
    // command word only moves with its strobe
    property p_cmd_hold;
        $changed(wr_cmd) |-> wr_valid;
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("wr_cmd changed without wr_valid");
endmodule
bind ddr_diag_results ddr_diag_results_sva u_sva (.sys_clk, .nrst, .sync_n, .sdo, .cal_start, .dac_range,
    .wr_valid, .wr_cmd, .rd_select);
`default_nettype wire

// ==== tb/ddr_spi_host.sv ====
// serial host model driving frames into the block
`timescale 1ns/1ps
`default_nettype none
module ddr_spi_host (
    // link pins
    output logic     sclk,
    output logic     sync_n,
    output logic     sdi,
    input wire logic sdo
);
    // idle link: clock still, frame deselected
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdi = 1'b0;
    end
    // one frame of n falling edges, msb first, readback shifted in
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
        r = 32'h0;
        #3; // step off the system clock edge
        sync_n = 1'b0;
        #50;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1;
            sdi = w[31-i];
            #80;
            r = {r[30:0], sdo};
            sclk = 1'b0;
            #80;
        end
        #30;
        sync_n = 1'b1;
        sdi = ~sdi; // released line has no pull
        #120;
    endtask
endmodule
`default_nettype wire

// ==== tb/ddr_diag_results_tb.sv ====
// self-checking bench for the diagnostic results block
`timescale 1ns/1ps
`default_nettype none
module ddr_diag_results_tb;
    logic                        sys_clk = 1'b0;
    logic                        nrst = 1'b0;
    logic                        sclk;
    logic                        sync_n;
    logic                        sdi;
    logic                        sdo;
    logic                        fault_pin = 1'b0;
    logic                        slew_active = 1'b0;
    logic                        crc_enable = 1'b0;
    logic [23:0]                 diag_enable = 24'hffffff;
    ddr_pkg::ddr_diag_cond_t     diag_cond = '0;
    logic                        cal_start;
    logic                        cal_done = 1'b0;
    logic [ddr_pkg::RANGE_W-1:0] dac_range;
    logic                        wr_valid;
    ddr_pkg::ddr_cmd_t           wr_cmd;
    logic [4:0]                  rd_select;
    logic [15:0]                 rd_data = 16'h5a3c;
    logic [23:0]                 rb;
    logic [23:0]                 m;
    logic [4:0]                  prev;
    int                          miscompares = 0;
    int                          num_checks = 0;
    int                          cal_cnt = 0;
    ddr_pkg::ddr_cmd_t           wr_seen = '0;

    // system clock
    always #5 sys_clk = ~sys_clk;
    // count refresh starts, keep the last strobed write
    always @(posedge sys_clk) begin
        if (cal_start === 1'b1) cal_cnt++;
        if (wr_valid === 1'b1) wr_seen <= wr_cmd;
    end

    ddr_diag_results uut (.sys_clk(sys_clk), .nrst(nrst), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo),
        .fault_pin(fault_pin), .slew_active(slew_active), .crc_enable(crc_enable), .diag_enable(diag_enable),
        .diag_cond(diag_cond), .cal_start(cal_start), .cal_done(cal_done), .dac_range(dac_range),
        .wr_valid(wr_valid), .wr_cmd(wr_cmd), .rd_select(rd_select), .rd_data(rd_data));
    ddr_spi_host host (.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo));

    // word compare
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one write frame, then settle time
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input int n, output logic [23:0] r);
        logic [31:0] w;
        host.xfer({3'h0, a, d, 8'h00}, n, w);
        r = w[23:0];
        repeat (8) @(posedge sys_clk);
    endtask
    // two-stage readback of one register
    task automatic rdreg(input logic [4:0] a, input logic [23:0] exp);
        wr(5'h13, {11'h0, a}, 24, rb);
        wr(5'h00, 16'h0, 24, rb);
        chk(rb, exp);
    endtask
    // refresh finished
    task automatic done_pulse;
        @(posedge sys_clk) cal_done <= 1'b1;
        @(posedge sys_clk) cal_done <= 1'b0;
    endtask
    task automatic t_reset;
        chk({19'h0, rd_select}, 24'h0);
        chk({20'h0, dac_range}, 24'h0);
        chk(24'(cal_cnt), 24'h1);
        rdreg(5'h14, 24'h14a000);
    endtask
    task automatic t_unref;
        wr(5'h06, 16'h0003, 24, rb);
        chk({20'h0, dac_range}, 24'h0);
        chk({3'h0, wr_seen}, 24'h130014);
        done_pulse();
        rdreg(5'h14, 24'h142010);
        wr(5'h14, 16'h2010, 24, rb);
        rdreg(5'h14, 24'h140000);
    endtask
    task automatic t_range;
        wr(5'h06, 16'h0003, 24, rb);
        chk({20'h0, dac_range}, 24'h3);
        chk({3'h0, wr_seen}, 24'h060003);
        chk(24'(cal_cnt), 24'h2);
        rdreg(5'h14, 24'h148000);
        done_pulse();
        wr(5'h06, 16'h0003, 24, rb);
        chk(24'(cal_cnt), 24'h2);
        rdreg(5'h14, 24'h140000);
    endtask
    task automatic t_sclk;
        @(posedge sys_clk) crc_enable <= 1'b1;
        wr(5'h00, 16'h0, 24, rb);
        @(posedge sys_clk) crc_enable <= 1'b0;
        rdreg(5'h14, 24'h140004);
        @(posedge sys_clk) diag_enable <= 24'hfffffb;
        rdreg(5'h14, 24'h140000);
        @(posedge sys_clk) diag_enable <= 24'hffffff;
        wr(5'h14, 16'h0004, 32, rb);
        rdreg(5'h14, 24'h140000);
        wr(5'h00, 16'h0, 20, rb);
        rdreg(5'h14, 24'h140004);
        wr(5'h14, 16'h0004, 24, rb);
    endtask
    task automatic t_cond;
        for (int k = 0; k < 4; k++) begin
            m = (k == 0) ? 24'h000800 : (k == 1) ? 24'h000100 : (k == 2) ? 24'h000040 : 24'h000020;
            @(posedge sys_clk) diag_cond <= ddr_pkg::ddr_diag_cond_t'(4'h8 >> k);
            rdreg(5'h14, 24'h140000 | m);
            wr(5'h14, m[15:0], 24, rb);
            @(posedge sys_clk) diag_cond <= '0;
            rdreg(5'h14, 24'h140000 | m);
            wr(5'h14, m[15:0], 24, rb);
            rdreg(5'h14, 24'h140000);
        end
    endtask
    task automatic t_pins;
        @(posedge sys_clk) fault_pin <= 1'b1;
        slew_active <= 1'b1;
        rdreg(5'h14, 24'h344000);
        @(posedge sys_clk) fault_pin <= 1'b0;
        slew_active <= 1'b0;
        rdreg(5'h14, 24'h140000);
    endtask
    task automatic t_sel;
        prev = 5'h14;
        for (int c = 4; c <= 28; c++) begin
            if (c inside {[11:14], [25:27]}) begin
                wr(5'h13, 16'(c), 24, rb);
                chk({19'h0, rd_select}, {19'h0, prev});
            end else if (c != 20) begin
                m = (c == 6) ? 24'h065a33 : (c == 19) ? 24'h130013 : {3'h0, 5'(c), rd_data};
                rdreg(5'(c), m);
                chk({19'h0, rd_select}, 24'(c));
                prev = 5'(c);
            end
        end
        wr(5'h13, 16'h0073, 24, rb);
        wr(5'h00, 16'h0, 24, rb);
        chk(rb, 24'h130073);
        rdreg(5'h14, 24'h140010);
    endtask
    // verdict and end of run
    task automatic print_verdict;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_unref();
        t_range();
        t_sclk();
        t_cond();
        t_pins();
        t_sel();
        print_verdict();
    end
    // watchdog
    initial begin
        #900000;
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
